// ### rtl/driver_supply_fault_supervisor.sv
`timescale 1ns/1ns
// What this block does
// - Holds 16-bit overvoltage fault threshold, writable
// - Overvoltage warning at ninety percent of fault
// - Holds 16-bit undervoltage fault threshold, writable
// - Undervoltage warning at 110 percent of fault
// - Response field: ignore, retry, or resume
// - Any mode: alert low, set fault bit
// - Retry mode: disable at once, then retry
// - Resume mode: re-enable below 95 percent
// - Retry count field sets restart attempts
// - Count zero: stay off until fault cleared or output commanded off
// - Count seven: retry without limit
// - Retry spacing is (time+1) times 35 ms
module driver_supply_fault_supervisor #(
    parameter int RETRY_UNIT = driver_supply_pkg::RETRY_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command port
    input wire driver_supply_pkg::cmd_s cmd,
    output driver_supply_pkg::rsp_s rsp,
    // Monitor and control
    input wire logic [15:0] driver_supply_monitor,
    input wire logic output_cmd_on,
    input wire logic clear_fault,
    // Results
    output logic output_enable,
    output logic alert_line_n,
    output driver_supply_pkg::status_s status
);
    import driver_supply_pkg::*;

    // ----------------------------------------------------------------
    // Internal state
    // ----------------------------------------------------------------
    sup_state_s q;
    sup_state_s next_q;
    logic ov_hit;
    logic ov_warn_hit;
    logic ov_resume_ok;
    logic uv_hit;
    logic uv_warn_hit;
    logic [1:0] resp_mode;
    logic [2:0] retry_field;
    logic [2:0] time_field;
    logic [2:0] tries_now;
    logic [DELAY_W-1:0] delay_load;

    // ----------------------------------------------------------------
    // Threshold comparison
    // ----------------------------------------------------------------
    // One raw sample over a limit counts; the reading is not filtered here
    // Purely combinational, so a threshold write takes effect from the next edge
    driver_supply_compare u_compare (
        .meas(driver_supply_monitor),
        .ov_threshold(q.ov_threshold),
        .uv_threshold(q.uv_threshold),
        .ov_hit(ov_hit),
        .ov_warn_hit(ov_warn_hit),
        .ov_resume_ok(ov_resume_ok),
        .uv_hit(uv_hit),
        .uv_warn_hit(uv_warn_hit)
    );

    // ----------------------------------------------------------------
    // Action field decode
    // ----------------------------------------------------------------
    assign resp_mode = q.ov_action[ACTION_RESP_MSB:ACTION_RESP_LSB];
    assign retry_field = q.ov_action[ACTION_RETRY_MSB:ACTION_RETRY_LSB];
    assign time_field = q.ov_action[ACTION_TIME_MSB:ACTION_TIME_LSB];
    // Down counter reaches zero one cycle short of (time+1) units; output returns after exactly (time+1)
    assign delay_load = DELAY_W'(({21'h0, time_field} + 24'h1) * DELAY_W'(RETRY_UNIT)) - 24'h1;
    // A fresh fault reloads the budget; a fault during retrying spends it
    // The budget only refills when the output is commanded off or a latch is released
    assign tries_now = q.retrying ? q.tries_left : retry_field;

    always_comb begin
        next_q = q;

        // ------------------------------------------------------------
        // Command decode
        // ------------------------------------------------------------
        next_q.rsp.valid = cmd.valid;
        next_q.rsp.ack = 1'b0;
        next_q.rsp.data = 16'h0000;
        if (cmd.valid) begin
            if (cmd.code == CMD_OV_FAULT_THRESHOLD) begin
                next_q.rsp.ack = 1'b1;
                next_q.rsp.data = q.ov_threshold;
                if (cmd.write) begin
                    next_q.ov_threshold = cmd.wdata;
                end
            end else if (cmd.code == CMD_UV_FAULT_THRESHOLD) begin
                next_q.rsp.ack = 1'b1;
                next_q.rsp.data = q.uv_threshold;
                if (cmd.write) begin
                    next_q.uv_threshold = cmd.wdata;
                end
            end else if (cmd.code == CMD_OV_FAULT_ACTION) begin
                next_q.rsp.ack = 1'b1;
                next_q.rsp.data = {8'h00, q.ov_action};
                if (cmd.write) begin
                    next_q.ov_action = cmd.wdata[7:0];
                end
            end
        end

        // ------------------------------------------------------------
        // Sticky status; a new event wins over a clear in one cycle
        // ------------------------------------------------------------
        if (clear_fault) begin
            next_q.status = '0;
        end
        if (ov_hit) begin
            next_q.status.ov_fault = 1'b1;
        end
        if (ov_warn_hit) begin
            next_q.status.ov_warn = 1'b1;
        end
        if (uv_hit) begin
            next_q.status.uv_fault = 1'b1;
        end
        if (uv_warn_hit) begin
            next_q.status.uv_warn = 1'b1;
        end
        // Undervoltage only flags and alerts; it has no response of its own
        next_q.alert_line_n = ~(next_q.status.ov_fault | next_q.status.uv_fault);

        // ------------------------------------------------------------
        // Overvoltage response
        // ------------------------------------------------------------
        case (q.st)
            ST_RUN: begin
                next_q.output_enable = output_cmd_on;
                if (!output_cmd_on) begin
                    next_q.retrying = 1'b0;
                end else if (ov_hit && resp_mode == RESP_RETRY) begin
                    next_q.output_enable = 1'b0;
                    if (tries_now == RETRY_NONE) begin
                        next_q.st = ST_LATCHED;
                    end else begin
                        next_q.st = ST_RETRY_WAIT;
                        next_q.tries_left = tries_now;
                        next_q.delay_cnt = delay_load;
                    end
                end else if (ov_hit && resp_mode == RESP_RESUME) begin
                    next_q.output_enable = 1'b0;
                    next_q.st = ST_RESUME_WAIT;
                end
                // Codes 00 and 01 fall through the full compares: output left alone
            end
            ST_RETRY_WAIT: begin
                next_q.output_enable = 1'b0;
                if (!output_cmd_on) begin
                    next_q.st = ST_RUN;
                    next_q.retrying = 1'b0;
                end else if (q.delay_cnt == '0) begin
                    next_q.st = ST_RUN;
                    next_q.output_enable = 1'b1;
                    next_q.retrying = 1'b1;
                    if (q.tries_left != RETRY_FOREVER) begin
                        next_q.tries_left = q.tries_left - 3'h1;
                    end
                end else begin
                    next_q.delay_cnt = q.delay_cnt - 24'h1;
                end
            end
            ST_LATCHED: begin
                next_q.output_enable = 1'b0;
                // Only a clear or a command off releases the latch
                if (clear_fault || !output_cmd_on) begin
                    next_q.st = ST_RUN;
                    next_q.retrying = 1'b0;
                end
            end
            ST_RESUME_WAIT: begin
                next_q.output_enable = 1'b0;
                if (!output_cmd_on) begin
                    next_q.st = ST_RUN;
                end else if (ov_resume_ok) begin
                    next_q.st = ST_RUN;
                    next_q.output_enable = 1'b1;
                end
            end
            default: begin
                next_q.st = ST_RUN;
                next_q.output_enable = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset loads each field from a constant; the live path copies next_q whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.ov_threshold <= OV_THRESHOLD_RESET;
            q.uv_threshold <= UV_THRESHOLD_RESET;
            q.ov_action <= OV_ACTION_RESET;
            q.st <= ST_RUN;
            q.delay_cnt <= '0;
            q.tries_left <= 3'h0;
            q.retrying <= 1'b0;
            q.output_enable <= 1'b0;
            q.alert_line_n <= 1'b1;
            q.status <= '0;
            q.rsp <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // All outputs are register bits, so the host never sees decode glitches
    assign output_enable = q.output_enable;
    assign alert_line_n = q.alert_line_n;
    assign status = q.status;
    assign rsp = q.rsp;
endmodule : driver_supply_fault_supervisor

// ### rtl/driver_supply_pkg.sv
package driver_supply_pkg;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_OV_FAULT_THRESHOLD = 8'hF5;
    localparam logic [7:0] CMD_UV_FAULT_THRESHOLD = 8'hF6;
    localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'hF8;

    // ----------------------------------------------------------------
    // Reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] OV_THRESHOLD_RESET = 16'h7BFF;
    localparam logic [15:0] UV_THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0] OV_ACTION_RESET = 8'h00;
    localparam int ACTION_RESP_MSB = 7;
    localparam int ACTION_RESP_LSB = 6;
    localparam int ACTION_RETRY_MSB = 5;
    localparam int ACTION_RETRY_LSB = 3;
    localparam int ACTION_TIME_MSB = 2;
    localparam int ACTION_TIME_LSB = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_RESUME = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // ----------------------------------------------------------------
    // Thresholds in percent of the fault limit
    // ----------------------------------------------------------------
    localparam logic [7:0] PCT_OV_WARN = 8'h5A;
    localparam logic [7:0] PCT_UV_WARN = 8'h6E;
    localparam logic [7:0] PCT_OV_RESUME = 8'h5F;
    localparam logic [7:0] PCT_FULL = 8'h64;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);
    localparam int DELAY_W = 24;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_RETRY_WAIT = 2'b01,
        ST_LATCHED = 2'b10,
        ST_RESUME_WAIT = 2'b11
    } sup_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [15:0] data;
    } rsp_s;

    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_fault;
        logic uv_warn;
    } status_s;

    typedef struct packed {
        logic [15:0] ov_threshold;
        logic [15:0] uv_threshold;
        logic [7:0] ov_action;
        sup_state_e st;
        logic [DELAY_W-1:0] delay_cnt;
        logic [2:0] tries_left;
        logic retrying;
        logic output_enable;
        logic alert_line_n;
        status_s status;
        rsp_s rsp;
    } sup_state_s;
endpackage : driver_supply_pkg

// ### rtl/driver_supply_compare.sv
`timescale 1ns/1ns
module driver_supply_compare (
    // Linear-format inputs
    input wire logic [15:0] meas,
    input wire logic [15:0] ov_threshold,
    input wire logic [15:0] uv_threshold,
    // Comparison results
    output logic ov_hit,
    output logic ov_warn_hit,
    output logic ov_resume_ok,
    output logic uv_hit,
    output logic uv_warn_hit
);
    import driver_supply_pkg::*;

    // ----------------------------------------------------------------
    // Linear to fixed point, 8 fraction bits
    // ----------------------------------------------------------------
    // Negative mantissas clamp to zero: a supply cannot be below ground
    function automatic logic [39:0] to_fixed(input logic [15:0] lin);
        logic signed [5:0] sh;
        logic [39:0] m;
        sh = 6'($signed(lin[15:11])) + 6'sd8;
        m = lin[10] ? 40'h0 : {30'h0, lin[9:0]};
        if (sh >= 0) begin
            to_fixed = m << sh;
        end else begin
            to_fixed = m >> (-sh);
        end
    endfunction : to_fixed

    logic [47:0] m_pct;
    logic [47:0] ov_fix;
    logic [47:0] uv_fix;

    always_comb begin
        m_pct = {8'h0, to_fixed(meas)} * {40'h0, PCT_FULL};
        ov_fix = {8'h0, to_fixed(ov_threshold)};
        uv_fix = {8'h0, to_fixed(uv_threshold)};
        ov_hit = m_pct > ov_fix * {40'h0, PCT_FULL};
        ov_warn_hit = m_pct > ov_fix * {40'h0, PCT_OV_WARN};
        ov_resume_ok = m_pct < ov_fix * {40'h0, PCT_OV_RESUME};
        uv_hit = m_pct < uv_fix * {40'h0, PCT_FULL};
        uv_warn_hit = m_pct < uv_fix * {40'h0, PCT_UV_WARN};
    end
endmodule : driver_supply_compare

// ### tb/sup_assertions.sv
`timescale 1ns/1ns
module sup_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire driver_supply_pkg::cmd_s cmd,
    input wire driver_supply_pkg::rsp_s rsp,
    input wire logic [15:0] driver_supply_monitor,
    input wire logic output_cmd_on,
    input wire logic output_enable,
    input wire logic alert_line_n,
    input wire driver_supply_pkg::status_s status
);
    import driver_supply_pkg::*;
    logic [15:0] ov;
    logic [15:0] uv;
    logic [7:0] act;
    logic [31:0] m;
    logic lin;
    // Only judged when every value is a plain positive mantissa
    assign lin = driver_supply_monitor[15:10] == 6'h00 && ov[15:10] == 6'h00 && uv[15:10] == 6'h00;
    assign m = {16'h0000, driver_supply_monitor};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ov <= OV_THRESHOLD_RESET;
            uv <= UV_THRESHOLD_RESET;
            act <= OV_ACTION_RESET;
        end else if (cmd.valid && cmd.write) begin
            case (cmd.code)
                CMD_OV_FAULT_THRESHOLD: ov <= cmd.wdata;
                CMD_UV_FAULT_THRESHOLD: uv <= cmd.wdata;
                CMD_OV_FAULT_ACTION: act <= cmd.wdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_ov_hit; lin && m > {16'h0000, ov}; endsequence
    sequence s_off; !output_enable; endsequence
    property p_answer; cmd.valid |=> rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("command not answered");
    property p_refuse; cmd.valid && cmd.code != CMD_OV_FAULT_THRESHOLD && cmd.code != CMD_UV_FAULT_THRESHOLD
        && cmd.code != CMD_OV_FAULT_ACTION |=> !rsp.ack && rsp.data == 16'h0000; endproperty
    a_refuse: assert property (p_refuse) else $error("unknown code accepted");
    property p_ov_fault; s_ov_hit |=> status.ov_fault; endproperty
    a_ov_fault: assert property (p_ov_fault) else $error("overvoltage not flagged");
    property p_ov_warn; lin && m * 10 >= ov * 9 + 10 |=> status.ov_warn; endproperty
    a_ov_warn: assert property (p_ov_warn) else $error("overvoltage warning missing");
    property p_uv_warn; lin && m * 10 + 10 <= uv * 11 |=> status.uv_warn; endproperty
    a_uv_warn: assert property (p_uv_warn) else $error("undervoltage warning missing");
    property p_alert; !alert_line_n == (status.ov_fault || status.uv_fault); endproperty
    a_alert: assert property (p_alert) else $error("alert line disagrees with status");
    property p_shut; output_cmd_on && output_enable && act[7] ##0 s_ov_hit |=> s_off; endproperty
    a_shut: assert property (p_shut) else $error("output not disabled on fault");
    property p_ignore; output_cmd_on && output_enable && !act[7] |=> output_enable; endproperty
    a_ignore: assert property (p_ignore) else $error("output dropped in ignore mode");
endmodule : sup_checker

bind driver_supply_fault_supervisor sup_checker sup_checker_i (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
    .driver_supply_monitor(driver_supply_monitor), .output_cmd_on(output_cmd_on),
    .output_enable(output_enable), .alert_line_n(alert_line_n), .status(status));

// ### tb/host_model.sv
`timescale 1ns/1ns
module host_model (
    // Clock
    input wire logic clk,
    // Command port
    output driver_supply_pkg::cmd_s cmd,
    input wire driver_supply_pkg::rsp_s rsp
);
    import driver_supply_pkg::*;
    initial cmd = '0;
    // One-cycle strobe; the answer is read once it has settled after the taking edge
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, output rsp_s r);
        @(posedge clk) cmd <= '{1'b1, wr, code, wd};
        @(posedge clk) cmd <= '0;
        #1 r = rsp;
    endtask : xfer
endmodule : host_model

// ### tb/driver_supply_fault_supervisor_test.sv
`timescale 1ns/1ns
module driver_supply_fault_supervisor_test;
    import driver_supply_pkg::*;
    localparam int UNIT = 4;
    localparam logic [15:0] OV_T = 16'h0064;
    localparam logic [15:0] UV_T = 16'h0032;
    localparam logic [15:0] SAFE = 16'h0046;
    logic clk;
    logic rst_n;
    cmd_s cmd;
    rsp_s rsp;
    logic [15:0] driver_supply_monitor;
    logic output_cmd_on;
    logic clear_fault;
    logic output_enable;
    logic alert_line_n;
    status_s status;
    int err_total = 0;
    int check_count = 0;
    driver_supply_fault_supervisor #(.RETRY_UNIT(UNIT)) driver_supply_fault_supervisor_i (.clk(clk), .rst_n(rst_n),
        .cmd(cmd), .rsp(rsp), .driver_supply_monitor(driver_supply_monitor), .output_cmd_on(output_cmd_on),
        .clear_fault(clear_fault), .output_enable(output_enable), .alert_line_n(alert_line_n), .status(status));
    host_model host_model_i (.clk(clk), .cmd(cmd), .rsp(rsp));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic probe(input logic [15:0] v);
        @(posedge clk) driver_supply_monitor <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask : probe
    // Sticky bits only drop while the condition is gone, so go safe first
    task automatic pulse_clear();
        @(posedge clk) driver_supply_monitor <= SAFE;
        @(posedge clk) clear_fault <= 1'b1;
        @(posedge clk) clear_fault <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse_clear
    task automatic t_regs();
        rsp_s r;
        host_model_i.xfer(1'b1, CMD_OV_FAULT_THRESHOLD, OV_T, r);
        check(r.data, OV_THRESHOLD_RESET);
        host_model_i.xfer(1'b1, CMD_UV_FAULT_THRESHOLD, UV_T, r);
        check(r.data, UV_THRESHOLD_RESET);
        host_model_i.xfer(1'b1, CMD_OV_FAULT_ACTION, 16'hAB00, r);
        check(r.data, {8'h00, OV_ACTION_RESET});
        host_model_i.xfer(1'b0, CMD_OV_FAULT_THRESHOLD, 16'h0000, r);
        check(r.data, OV_T);
        host_model_i.xfer(1'b0, CMD_UV_FAULT_THRESHOLD, 16'h0000, r);
        check(r.data, UV_T);
        host_model_i.xfer(1'b0, CMD_OV_FAULT_ACTION, 16'h0000, r);
        check(r.data, 16'h0000);
        host_model_i.xfer(1'b1, 8'hF7, 16'h1234, r);
        check({r.valid, r.ack, r.data}, {2'b10, 16'h0000});
    endtask : t_regs
    task automatic t_warn();
        probe(OV_T * 16'h0009 / 16'h000A);
        check(status.ov_warn, 1'b0);
        probe(OV_T * 16'h0009 / 16'h000A + 16'h0001);
        check({status, alert_line_n}, 5'b01001);
        probe(UV_T * 16'h000B / 16'h000A);
        check(status.uv_warn, 1'b0);
        probe(UV_T * 16'h000B / 16'h000A - 16'h0001);
        check(status.uv_warn, 1'b1);
        probe(UV_T - 16'h0001);
        check({status.uv_fault, alert_line_n}, 2'b10);
        pulse_clear();
        check({status, alert_line_n}, 5'b00001);
    endtask : t_warn
    task automatic t_ignore();
        rsp_s r;
        for (int i = 0; i < 2; i++) begin
            host_model_i.xfer(1'b1, CMD_OV_FAULT_ACTION, {8'h00, i[1:0], 6'h00}, r);
            probe(OV_T + 16'h0001);
            check({output_enable, alert_line_n, status.ov_fault}, 3'b101);
            pulse_clear();
        end
    endtask : t_ignore
    task automatic t_retry(input logic [7:0] act, input int faults, input int back);
        rsp_s r;
        int n;
        host_model_i.xfer(1'b1, CMD_OV_FAULT_ACTION, {8'h00, act}, r);
        for (int i = 0; i < faults; i++) begin
            @(posedge clk) driver_supply_monitor <= OV_T + 16'h0001;
            @(posedge clk) driver_supply_monitor <= SAFE;
            #1 check({output_enable, alert_line_n}, 2'b00);
            n = 0;
            while (output_enable !== 1'b1 && n < 40) begin
                @(posedge clk);
                #1 n++;
            end
            if (i < back) check(n, (act[2:0] + 1) * UNIT);
            else check(output_enable, 1'b0);
        end
        pulse_clear();
        check(output_enable, 1'b1);
    endtask : t_retry
    task automatic t_resume();
        rsp_s r;
        host_model_i.xfer(1'b1, CMD_OV_FAULT_ACTION, 16'h00C0, r);
        probe(OV_T + 16'h0001);
        probe(OV_T * 16'h005F / 16'h0064 + 16'h0001);
        check(output_enable, 1'b0);
        probe(OV_T * 16'h005F / 16'h0064 - 16'h0001);
        check(output_enable, 1'b1);
        @(posedge clk) output_cmd_on <= 1'b0;
        @(posedge clk);
        #1 check(output_enable, 1'b0);
        @(posedge clk) output_cmd_on <= 1'b1;
        pulse_clear();
        check(output_enable, 1'b1);
    endtask : t_resume
    initial begin
        rst_n = 1'b0;
        output_cmd_on = 1'b1;
        clear_fault = 1'b0;
        driver_supply_monitor = SAFE;
        repeat (2) @(posedge clk);
        #1 check({output_enable, alert_line_n, status, rsp}, {6'h10, 18'h00000});
        @(posedge clk) rst_n <= 1'b1;
        // First live edge: output follows the command, nothing flagged yet
        @(posedge clk);
        #1 check({output_enable, alert_line_n, status}, 6'h30);
        t_regs();
        t_warn();
        t_ignore();
        t_retry(8'h89, 2, 1);
        t_retry(8'h80, 1, 0);
        t_retry(8'hB8, 3, 3);
        t_resume();
        finish_test();
    end
    // The whole sequence needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        err_total++;
        finish_test();
    end
endmodule : driver_supply_fault_supervisor_test
